// ==== wtrap_pkg.sv ====
/*
  Constants, codes and types of the watchdog reset path and fetch trap.
  Assumes one 100 MHz clock shared with the processor core.
  // Overview of operation
  // - overflow with output select at reset raises a reset request.
  // - watchdog or trap reset lasts at most 24 fast clock periods.
  // - reset in low-speed mode one restarts fast oscillator, same bound.
  // - command value 4e clears the watchdog counter.
  // - command b1 disables the watchdog; unknown codes do nothing.
  // - new ram trap select applies only after command d2 is written.
  // - ram trap select high makes fetches from internal ram trap.
  // - fetches from special-function or debug areas always trap.
  // - trap action select low makes a trap raise its interrupt.
  // - trap action select high makes a trap raise a reset request.
  // - trap interrupt is non-maskable, ignores the interrupt master flag.
  // - a new trap is requested at once even while another is serviced.
  // - overflow with output select low raises a watchdog interrupt.
  // - disable command only acts while the enable bit is low.
  // - output select once cleared cannot be set again until reset.
*/
package wtrap_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FETCH_W = 16;
  localparam int STS_W = 4;

  // register offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h01;
  localparam logic [7:0] ADDR_STS = 8'h02;
  localparam logic [7:0] ADDR_MSK = 8'h03;
  localparam logic [7:0] ADDR_STATE = 8'h04;

  // command codes
  localparam logic [7:0] CODE_CLEAR = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam logic [7:0] CODE_TRAP_AREA = 8'hd2;

  // watchdog_config_reg fields
  localparam int CFG_OUT_SEL = 0;
  localparam int CFG_TIME_LO = 1;
  localparam int CFG_TIME_HI = 2;
  localparam int CFG_ENABLE = 3;
  localparam int CFG_TRAP_ACT = 6;
  localparam int CFG_RAM_TRAP = 7;

  // status and mask bits
  localparam int ST_WDT_NMI = 0;
  localparam int ST_TRAP_NMI = 1;
  localparam int ST_WDT_RST = 2;
  localparam int ST_TRAP_RST = 3;

  // reset values of configuration
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_OUT_SEL = 1'b1;
  localparam logic RST_RAM_TRAP = 1'b1;
  localparam logic RST_TRAP_ACT = 1'b1;
  localparam logic [1:0] RST_TIME = 2'h0;

  // fetch areas, inclusive bounds
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003f;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h023f;
  localparam logic [15:0] DBR_LO = 16'h0f80;
  localparam logic [15:0] DBR_HI = 16'h0fff;

  // reset pulse length: 24 fc periods, fc being the block clock
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FC_PERIOD_PS = 10000;
  localparam int RST_MAX_FC_PERIODS = 24;
  localparam int RST_MAX_PS = RST_MAX_FC_PERIODS * FC_PERIOD_PS;
  localparam int RST_CYC = RST_MAX_PS / CLK_PERIOD_PS;
  localparam int RCNT_W = 5;
  localparam logic [4:0] RST_LAST = 5'(RST_CYC - 1);
  localparam logic [4:0] RCNT_ZERO = 5'h00;
  localparam logic [4:0] RCNT_ONE = 5'h01;

  typedef enum logic [1:0] {
    WTRAP_IDLE = 2'b01,
    WTRAP_HOLD = 2'b10
  } wtrap_rst_st_t;

endpackage

// ==== wtrap_top.sv ====
/*
  Watchdog counter, command port decode, fetch address trap and the
  internal reset pulse generator, with status, mask and interrupt.
  Assumes the processor core drives the register port and fetch bus
  on the same clock, and that the system reset it requests also
  drives rstn of this block.
*/
`timescale 1ns/1ps
`default_nettype none

module wtrap_top #(
  parameter int OVF_LOG2 = 25
) (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic [wtrap_pkg::ADDR_W-1:0]         regAddr,
  input  wire logic [wtrap_pkg::DATA_W-1:0]         regWdata,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  output logic      [wtrap_pkg::DATA_W-1:0]         regRdata,
  input  wire logic                                 fetchValid,
  input  wire logic [wtrap_pkg::FETCH_W-1:0]        fetchAddr,
  input  wire logic                                 lowSpeedMode,
  output logic                                      watchdogNmi,
  output logic                                      trapNmi,
  output logic                                      hwResetReq,
  output logic                                      hfOscRestart,
  output logic                                      irq
);

  function automatic logic inArea(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    inArea = (a >= lo) && (a <= hi);
  endfunction

  // configuration and state
  logic                          cfgEn_r;
  logic                          outSel_r;
  logic [1:0]                    timeSel_r;
  logic                          ramSel_r;
  logic                          ramAct_r;
  logic                          trapAct_r;
  logic                          running_r;
  logic [OVF_LOG2-1:0]           cnt_r;
  logic [wtrap_pkg::STS_W-1:0]   status_r;
  logic [wtrap_pkg::STS_W-1:0]   mask_r;
  wtrap_pkg::wtrap_rst_st_t      rstSt_r;
  logic [wtrap_pkg::RCNT_W-1:0]  rstCnt_r;

  logic                          outSel_nxt;
  logic                          running_nxt;
  logic [OVF_LOG2-1:0]           cnt_nxt;
  logic [wtrap_pkg::STS_W-1:0]   status_nxt;
  logic [wtrap_pkg::STS_W-1:0]   mask_nxt;
  logic [wtrap_pkg::DATA_W-1:0]  regRdata_nxt;
  wtrap_pkg::wtrap_rst_st_t      rstSt_nxt;
  logic [wtrap_pkg::RCNT_W-1:0]  rstCnt_nxt;

  // register port decode
  wire cfgWr = regWr && (regAddr == wtrap_pkg::ADDR_CFG);
  wire cmdWr = regWr && (regAddr == wtrap_pkg::ADDR_CMD);
  wire stsWr = regWr && (regAddr == wtrap_pkg::ADDR_STS);
  wire mskWr = regWr && (regAddr == wtrap_pkg::ADDR_MSK);

  wire clrCode = cmdWr && (regWdata == wtrap_pkg::CODE_CLEAR);
  wire disCode = cmdWr && (regWdata == wtrap_pkg::CODE_DISABLE)
                 && !cfgEn_r;
  wire areaCode = cmdWr && (regWdata == wtrap_pkg::CODE_TRAP_AREA);

  // watchdog counter and overflow at the selected detection time
  wire [OVF_LOG2-1:0] ovfLimit = {OVF_LOG2{1'b1}} >> {timeSel_r, 1'b0};
  wire ovf = running_r && (cnt_r == ovfLimit);

  // fetch trap detection
  wire inRam = inArea(fetchAddr, wtrap_pkg::RAM_LO, wtrap_pkg::RAM_HI);
  wire inSfr = inArea(fetchAddr, wtrap_pkg::SFR_LO, wtrap_pkg::SFR_HI);
  wire inDbr = inArea(fetchAddr, wtrap_pkg::DBR_LO, wtrap_pkg::DBR_HI);
  wire trapHit = fetchValid
                 && ((inRam && ramAct_r)
                     || inSfr || inDbr);

  // event decode
  wire evWdtNmi = ovf && !outSel_r;
  wire evWdtRst = ovf && outSel_r;
  wire evTrapNmi = trapHit && !trapAct_r;
  wire evTrapRst = trapHit && trapAct_r;
  wire rstFire = evWdtRst || evTrapRst;
  wire rstIdle = (rstSt_r == wtrap_pkg::WTRAP_IDLE);

  wire [wtrap_pkg::STS_W-1:0] events = {evTrapRst, evWdtRst,
                                        evTrapNmi, evWdtNmi};
  wire [wtrap_pkg::STS_W-1:0] stsClr =
    stsWr ? regWdata[wtrap_pkg::STS_W-1:0] : '0;

  // output select can only be lowered
  assign outSel_nxt = cfgWr ? (regWdata[wtrap_pkg::CFG_OUT_SEL] & outSel_r)
                            : outSel_r;

  // enable restarts the watchdog, the disable code stops it
  assign running_nxt = (cfgWr && regWdata[wtrap_pkg::CFG_ENABLE]) ? 1'b1 :
                       disCode ? 1'b0 : running_r;

  // counter held clear while stopped
  assign cnt_nxt = (!running_r || clrCode || ovf) ? '0 :
                   cnt_r + 1'b1;

  // set wins over write-one-to-clear
  assign status_nxt = (status_r & ~stsClr) | events;
  assign mask_nxt = mskWr ? regWdata[wtrap_pkg::STS_W-1:0] : mask_r;

  // read mux, zero for write-only and unmapped offsets
  wire [wtrap_pkg::DATA_W-1:0] rdSts = {{(wtrap_pkg::DATA_W -
                                          wtrap_pkg::STS_W){1'b0}}, status_r};
  wire [wtrap_pkg::DATA_W-1:0] rdMsk = {{(wtrap_pkg::DATA_W -
                                          wtrap_pkg::STS_W){1'b0}}, mask_r};
  wire [wtrap_pkg::DATA_W-1:0] rdState = {3'h0, hwResetReq, trapAct_r,
                                          ramAct_r, outSel_r, running_r};
  wire [wtrap_pkg::DATA_W-1:0] rdMux;
  assign rdMux = (regAddr == wtrap_pkg::ADDR_STS)   ? rdSts :
                 (regAddr == wtrap_pkg::ADDR_MSK)   ? rdMsk :
                 (regAddr == wtrap_pkg::ADDR_STATE) ? rdState :
                 8'h00;
  assign regRdata_nxt = regRd ? rdMux : 8'h00;

  // reset pulse sequencer
  always_comb begin
    rstSt_nxt = rstSt_r;
    rstCnt_nxt = rstCnt_r;
    case (rstSt_r)
      wtrap_pkg::WTRAP_IDLE: begin
        if (rstFire) begin
          rstSt_nxt = wtrap_pkg::WTRAP_HOLD;
          rstCnt_nxt = wtrap_pkg::RST_LAST;
        end
      end
      wtrap_pkg::WTRAP_HOLD: begin
        if (rstCnt_r == wtrap_pkg::RCNT_ZERO) begin
          rstSt_nxt = wtrap_pkg::WTRAP_IDLE;
        end else begin
          rstCnt_nxt = rstCnt_r - wtrap_pkg::RCNT_ONE;
        end
      end
      default: begin
        rstSt_nxt = wtrap_pkg::WTRAP_IDLE;
        rstCnt_nxt = wtrap_pkg::RCNT_ZERO;
      end
    endcase
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgEn_r <= wtrap_pkg::RST_ENABLE;
      outSel_r <= wtrap_pkg::RST_OUT_SEL;
      timeSel_r <= wtrap_pkg::RST_TIME;
      ramSel_r <= wtrap_pkg::RST_RAM_TRAP;
      ramAct_r <= wtrap_pkg::RST_RAM_TRAP;
      trapAct_r <= wtrap_pkg::RST_TRAP_ACT;
      running_r <= wtrap_pkg::RST_ENABLE;
    end else begin
      outSel_r <= outSel_nxt;
      running_r <= running_nxt;
      if (cfgWr) begin
        cfgEn_r <= regWdata[wtrap_pkg::CFG_ENABLE];
        timeSel_r <= regWdata[wtrap_pkg::CFG_TIME_HI:wtrap_pkg::CFG_TIME_LO];
        ramSel_r <= regWdata[wtrap_pkg::CFG_RAM_TRAP];
        trapAct_r <= regWdata[wtrap_pkg::CFG_TRAP_ACT];
      end
      if (areaCode) begin
        ramAct_r <= ramSel_r;
      end
    end
  end

  // counter, status and interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      status_r <= '0;
      mask_r <= '0;
      irq <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq <= |(status_nxt & mask_nxt);
      regRdata <= regRdata_nxt;
    end
  end

  // request outputs; traps ignore the master flag and any nesting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdogNmi <= 1'b0;
      trapNmi <= 1'b0;
      hfOscRestart <= 1'b0;
      hwResetReq <= 1'b0;
      rstSt_r <= wtrap_pkg::WTRAP_IDLE;
      rstCnt_r <= wtrap_pkg::RCNT_ZERO;
    end else begin
      watchdogNmi <= evWdtNmi;
      trapNmi <= evTrapNmi;
      hfOscRestart <= rstFire && rstIdle && lowSpeedMode;
      hwResetReq <= (rstSt_nxt == wtrap_pkg::WTRAP_HOLD);
      rstSt_r <= rstSt_nxt;
      rstCnt_r <= rstCnt_nxt;
    end
  end

  // assertion helper: length of the current reset pulse
  logic [wtrap_pkg::RCNT_W:0] hiLen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiLen <= '0;
    end else begin
      hiLen <= hwResetReq ? hiLen + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_wdt_reset_req: assert property (
    (ovf && outSel_r && rstIdle) |=> hwResetReq [*8])
    else $error("overflow in reset mode gave no reset request");

  a_reset_len_max: assert property (
    hiLen <= 6'(wtrap_pkg::RST_CYC))
    else $error("reset request longer than 24 fast clock periods");

  a_reset_len_end: assert property (
    $rose(hwResetReq) |-> ##23 hwResetReq ##1 !hwResetReq)
    else $error("reset request pulse length is not 24 cycles");

  a_osc_restart: assert property (
    (rstFire && rstIdle && lowSpeedMode) |=> hfOscRestart && hwResetReq)
    else $error("low-speed reset did not restart fast oscillator");

  a_clear_code: assert property (
    clrCode |=> (cnt_r == '0))
    else $error("clear code left watchdog counter nonzero");

  a_disable_code: assert property (
    (disCode && !(cfgWr)) |=> !running_r ##1 (cnt_r == '0))
    else $error("disable code did not stop the watchdog");

  a_disable_guard: assert property (
    (cmdWr && cfgEn_r && running_r) |=> running_r)
    else $error("watchdog stopped while enable bit set");

  a_ram_apply: assert property (
    !areaCode |=> (ramAct_r == $past(ramAct_r)))
    else $error("ram trap setting changed without area code");

  a_ram_trap: assert property (
    (fetchValid && inRam && ramAct_r && !trapAct_r) |=> trapNmi)
    else $error("ram fetch did not trap");

  a_sys_trap: assert property (
    (fetchValid && (inSfr || inDbr)) |=> (trapNmi || hwResetReq))
    else $error("register area fetch did not trap");

  a_trap_irq: assert property (
    trapNmi |-> $past(trapHit) && !$past(trapAct_r))
    else $error("trap interrupt without a trap in interrupt mode");

  a_trap_reset: assert property (
    (trapHit && trapAct_r && rstIdle) |=> hwResetReq && !trapNmi)
    else $error("trap in reset mode gave no reset request");

  a_wdt_nmi: assert property (
    (ovf && !outSel_r && !trapHit && rstIdle) |=> watchdogNmi && !hwResetReq)
    else $error("overflow in interrupt mode gave no interrupt");

  a_outsel_lock: assert property (
    !outSel_r |=> !outSel_r)
    else $error("output select returned to reset mode");

  a_wdt_nmi_src: assert property (
    watchdogNmi |-> $past(ovf) && !$past(outSel_r))
    else $error("watchdog interrupt without overflow in interrupt mode");

  a_reset_src: assert property (
    $rose(hwResetReq) |-> $past(rstFire))
    else $error("reset request rose without a reset event");

  a_osc_src: assert property (
    hfOscRestart |-> $past(lowSpeedMode) && $rose(hwResetReq))
    else $error("oscillator restart outside a low-speed reset start");

  a_osc_pulse: assert property (
    hfOscRestart |=> !hfOscRestart)
    else $error("oscillator restart longer than one cycle");

  a_reset_count: assert property (
    (!rstIdle && (rstCnt_r != wtrap_pkg::RCNT_ZERO))
      |=> (rstCnt_r == $past(rstCnt_r) - wtrap_pkg::RCNT_ONE))
    else $error("reset pulse counter did not step down");

  a_reset_idle: assert property (
    (rstIdle && !rstFire) |=> !hwResetReq)
    else $error("reset request raised with no reset event");

  a_sts_wdt_nmi: assert property (
    evWdtNmi |=> status_r[wtrap_pkg::ST_WDT_NMI])
    else $error("watchdog interrupt event not recorded");

  a_sts_trap_nmi: assert property (
    evTrapNmi |=> status_r[wtrap_pkg::ST_TRAP_NMI])
    else $error("trap interrupt event not recorded");

  a_sts_wdt_rst: assert property (
    evWdtRst |=> status_r[wtrap_pkg::ST_WDT_RST])
    else $error("watchdog reset event not recorded");

  a_sts_trap_rst: assert property (
    evTrapRst |=> status_r[wtrap_pkg::ST_TRAP_RST])
    else $error("trap reset event not recorded");

  a_stop_clear: assert property (
    !running_r |=> (cnt_r == '0))
    else $error("watchdog counter moved while stopped");

  a_area_load: assert property (
    areaCode |=> (ramAct_r == $past(ramSel_r)))
    else $error("area code did not apply the ram trap setting");

  a_enable_run: assert property (
    (cfgWr && regWdata[wtrap_pkg::CFG_ENABLE]) |=> running_r)
    else $error("enable write did not restart the watchdog");

  a_bad_code: assert property (
    (cmdWr && (regWdata != wtrap_pkg::CODE_DISABLE))
      |=> (running_r == $past(running_r)))
    else $error("command other than disable changed the run state");

  a_ram_pass: assert property (
    (fetchValid && inRam && !ramAct_r && !ovf)
      |=> !trapNmi && !$rose(hwResetReq))
    else $error("ram fetch trapped with ram trap off");

  a_outsel_hold: assert property (
    !cfgWr |=> (outSel_r == $past(outSel_r)))
    else $error("output select changed without a config write");

endmodule

`default_nettype wire

// ==== wtrap_core.sv ====
/*
  core model: register port writes and reads, instruction fetches and
  the low-speed mode flag, all changed right after a rising edge.
  assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
`default_nettype none

module wtrap_core (
  input  wire logic        clk,
  output logic       [7:0] regAddr,
  output logic       [7:0] regWdata,
  output logic             regWr,
  output logic             regRd,
  output logic             fetchValid,
  output logic      [15:0] fetchAddr,
  output logic             lowSpeedMode
);
  initial begin
    {regAddr, regWdata, regWr, regRd} = '0;
    {fetchValid, fetchAddr, lowSpeedMode} = '0;
  end

  // one strobe cycle, then an idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= w;
    regRd    <= !w;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask

  task automatic fetch(input logic v, input logic [15:0] a);
    @(posedge clk);
    fetchValid <= v;
    fetchAddr  <= a;
  endtask

  task automatic slow(input logic v);
    @(posedge clk);
    lowSpeedMode <= v;
  endtask
endmodule

`default_nettype wire

// ==== testbench.sv ====
/*
  self-checking bench of the watchdog and fetch trap block.
  assumes the core model drives every request port of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk, rstn, regWr, regRd, fetchValid, lowSpeedMode;
  logic  [7:0] regAddr, regWdata, regRdata, seed;
  logic [15:0] fetchAddr;
  logic        watchdogNmi, trapNmi, hwResetReq, hfOscRestart, irq;
  logic        rdSeen = 1'b0;
  logic        rstPrev = 1'b0;
  logic  [3:0] ev, evExp;
  logic  [7:0] rdQ[$];
  logic  [3:0] evQ[$];
  logic [15:0] edges[8] = '{16'h003f, 16'h0040, 16'h023f, 16'h0240,
                            16'h0f7f, 16'h0f80, 16'h0fff, 16'h1000};
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          rstLen = 0;

  wtrap_core core (
    .clk          (clk),
    .regAddr      (regAddr),
    .regWdata     (regWdata),
    .regWr        (regWr),
    .regRd        (regRd),
    .fetchValid   (fetchValid),
    .fetchAddr    (fetchAddr),
    .lowSpeedMode (lowSpeedMode)
  );
  wtrap_top #(
    .OVF_LOG2 (6)
  ) dut (
    .clk          (clk),
    .rstn         (rstn),
    .regAddr      (regAddr),
    .regWdata     (regWdata),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdata     (regRdata),
    .fetchValid   (fetchValid),
    .fetchAddr    (fetchAddr),
    .lowSpeedMode (lowSpeedMode),
    .watchdogNmi  (watchdogNmi),
    .trapNmi      (trapNmi),
    .hwResetReq   (hwResetReq),
    .hfOscRestart (hfOscRestart),
    .irq          (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic ram);
    return (a <= wtrap_pkg::SFR_HI) ||
           (a >= wtrap_pkg::DBR_LO && a <= wtrap_pkg::DBR_HI) ||
           (ram && a >= wtrap_pkg::RAM_LO && a <= wtrap_pkg::RAM_HI);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rdQ.push_back(exp);
    core.bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.bus(1'b1, a, d);
  endtask

  // e is the expected event vector if the fetch should trap
  task automatic go(input logic [15:0] a, input logic ram, input logic [3:0] e);
    if (hit(a, ram)) evQ.push_back(e);
    core.fetch(1'b1, a);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while ((evQ.size() != 0 || hwResetReq !== 1'b0) && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(8'(evQ.size()), 8'h00);
    @(negedge clk);
  endtask

  task automatic irqIs(input logic v);
    @(negedge clk);
    chk({7'h0, irq}, {7'h0, v});
  endtask

  // results are compared where they appear, oldest note first
  always @(negedge clk) begin
    if (rdSeen) chk(regRdata, rdQ.size() ? rdQ.pop_front() : 8'hxx);
    rdSeen = regRd;
    ev = {hfOscRestart, hwResetReq & ~rstPrev, trapNmi, watchdogNmi};
    rstPrev = hwResetReq;
    if (ev !== 4'h0) begin
      evExp = evQ.size() ? evQ.pop_front() : 4'h0;
      chk({6'h0, ev[1:0]}, {6'h0, evExp[1:0]});
      chk({6'h0, ev[3:2]}, {6'h0, evExp[3:2]});
    end
    if (hwResetReq) rstLen++;
    else if (rstLen != 0) begin
      chk(8'(rstLen), 8'(wtrap_pkg::RST_MAX_FC_PERIODS));
      rstLen = 0;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out;
    end
  end

  initial begin
    rstn = 1'b0;
    seed = 8'h42;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(wtrap_pkg::ADDR_STATE, 8'h0f);
    rd(wtrap_pkg::ADDR_CFG, 8'h00);
    rd(8'h7f, 8'h00);
    rd(wtrap_pkg::ADDR_MSK, 8'h00);
    core.slow(1'b1);
    evQ.push_back(4'hc);
    drain;
    core.slow(1'b0);
    irqIs(1'b0);
    rd(wtrap_pkg::ADDR_STS, 8'h04);
    wr(wtrap_pkg::ADDR_MSK, 8'h0f);
    irqIs(1'b1);
    wr(wtrap_pkg::ADDR_STS, 8'h0f);
    irqIs(1'b0);
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_CLEAR);
    wr(wtrap_pkg::ADDR_CFG, 8'h88);
    wr(wtrap_pkg::ADDR_CFG, 8'h89);
    rd(wtrap_pkg::ADDR_STATE, 8'h05);
    repeat (30) @(posedge clk);
    evQ.push_back(4'h1);
    drain;
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_CLEAR);
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_DISABLE);
    rd(wtrap_pkg::ADDR_STATE, 8'h05);
    wr(wtrap_pkg::ADDR_CFG, 8'h80);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      if (seed inside {8'h4e, 8'hb1, 8'hd2}) seed = seed ^ 8'h01;
      wr(wtrap_pkg::ADDR_CMD, seed);
    end
    rd(wtrap_pkg::ADDR_STATE, 8'h05);
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_DISABLE);
    rd(wtrap_pkg::ADDR_STATE, 8'h04);
    wr(wtrap_pkg::ADDR_STS, 8'h0f);
    foreach (edges[i]) go(edges[i], 1'b1, 4'h2);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      go(16'({seed, 4'h0}), 1'b1, 4'h2);
    end
    // burst ends and every trap is drained before the next
    core.fetch(1'b0, 16'h0000);
    drain;
    rd(wtrap_pkg::ADDR_STS, 8'h02);
    irqIs(1'b1);
    wr(wtrap_pkg::ADDR_STS, 8'h0f);
    wr(wtrap_pkg::ADDR_CFG, 8'h00);
    go(16'h0100, 1'b1, 4'h2);
    core.fetch(1'b0, 16'h0000);
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_TRAP_AREA);
    go(16'h0100, 1'b0, 4'h2);
    go(16'h0000, 1'b0, 4'h2);
    core.fetch(1'b0, 16'h0000);
    drain;
    rd(wtrap_pkg::ADDR_STATE, 8'h00);
    wr(wtrap_pkg::ADDR_CFG, 8'h40);
    core.slow(1'b1);
    go(16'h0020, 1'b0, 4'hc);
    core.fetch(1'b0, 16'h0000);
    core.slow(1'b0);
    drain;
    go(16'h0fc0, 1'b0, 4'h4);
    core.fetch(1'b0, 16'h0000);
    drain;
    rd(wtrap_pkg::ADDR_STS, 8'h0a);
    rd(wtrap_pkg::ADDR_STATE, 8'h08);
    // shorter detection time: overflow exactly 16 cycles after enable
    wr(wtrap_pkg::ADDR_CFG, 8'h4a);
    repeat (16) @(posedge clk);
    evQ.push_back(4'h1);
    @(negedge clk);
    @(posedge clk);
    chk(8'(evQ.size()), 8'h00);
    wr(wtrap_pkg::ADDR_CFG, 8'h40);
    wr(wtrap_pkg::ADDR_CMD, wtrap_pkg::CODE_DISABLE);
    rd(wtrap_pkg::ADDR_STS, 8'h0b);
    repeat (2) @(negedge clk);
    close_out;
  end
endmodule

`default_nettype wire
